// File: rtl/sim_map.svh
`ifndef SIM_MAP_SVH
`define SIM_MAP_SVH

// Register byte offsets on the Avalon-MM slave
`define SIM_REG_CTRL       4'h0
`define SIM_REG_STATUS     4'h4
`define SIM_REG_IRQ_STAT   4'h8
`define SIM_REG_IRQ_MASK   4'hC

// Control register fields
`define SIM_CTRL_RESET_CMD 0

// Status register fields
`define SIM_ST_ESTOP       0
`define SIM_ST_PROHIBIT    1
`define SIM_ST_DOOR_OPEN   2
`define SIM_ST_DOOR_LATCH  3
`define SIM_ST_TEACH_LATCH 4
`define SIM_ST_CRIT_DOOR   5
`define SIM_ST_CRIT_STOP   6
`define SIM_ST_RELEASE     7
`define SIM_ST_STOP_OK     8
`define SIM_ST_DOOR_OK     9
`define SIM_ST_TEACH_SEL   10

// Interrupt status and mask fields
`define SIM_IRQ_ESTOP      0
`define SIM_IRQ_CRIT       1
`define SIM_IRQ_DOOR       2
`define SIM_IRQ_TEACH      3
`define SIM_IRQ_W          4
`define SIM_IRQ_MASK_RST   4'h0

// Filtered input vector positions
`define SIM_IN_STOP_A      0
`define SIM_IN_STOP_B      1
`define SIM_IN_DOOR_A      2
`define SIM_IN_DOOR_B      3
`define SIM_IN_RELEASE     4
`define SIM_IN_TEACH       5
`define SIM_IN_W           6

// Timing
`define SIM_CLK_MHZ        200
`define SIM_FILT_TIME_US   10
`define SIM_FILT_CYCLES    (`SIM_FILT_TIME_US * `SIM_CLK_MHZ)
`define SIM_DISC_TIME_S    2
`define SIM_DISC_CYCLES    (`SIM_DISC_TIME_S * `SIM_CLK_MHZ * 1000000)

`endif

// File: rtl/sim_pkg.sv
package sim_pkg;

	// Emergency stop sequencer, one-hot
	typedef enum logic [2:0] {
		SIM_RUN   = 3'b001,
		SIM_STOP  = 3'b010,
		SIM_ARMED = 3'b100
	} sim_state_t;

endpackage

// File: rtl/sim_monitor.sv
// Contract
// - Door channels disagree two seconds: critical error
// - Stop channels disagree two seconds: critical error
// - Keep latched door-open and teaching records
// - Release open: capture and hold conditions
// - Release closed: clear held conditions
// - Release closed: door status follows live
// - Door still open keeps power prohibited
// - Leave stop after contacts restored, then reset
// - Open door forces hold and prohibited power
// - Unconnected inputs read open, hence unsafe
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`include "sim_map.svh"
module sim_monitor #(
	parameter int unsigned FILT_CYCLES = `SIM_FILT_CYCLES,
	parameter int unsigned DISC_CYCLES = `SIM_DISC_CYCLES
) (
	input  wire logic        i_mclk,
	input  wire logic        i_reset,
	input  wire logic        i_ce,
	input  wire logic        i_stop_circuit_a_pos,
	input  wire logic        i_stop_circuit_b_pos,
	input  wire logic        i_door_input_a_first,
	input  wire logic        i_door_input_b_first,
	input  wire logic        i_latch_release_in_first,
	input  wire logic        i_teach_mode_sel,
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	output logic             o_estop,
	output logic             o_power_prohibit,
	output logic             o_prog_hold,
	output logic             o_critical_error,
	output logic             o_teach_latched,
	output logic             o_irq
);
	// Refuse counts the counters cannot serve
	if (FILT_CYCLES < 1 || DISC_CYCLES < 1) begin : g_bad_param
		$error("sim_monitor: cycle counts must be at least one");
	end
	// Saturating increment shared by the filter and discrepancy counters
	function automatic logic [31:0] sat_inc(input logic [31:0] v);
		sat_inc = (v == 32'hFFFFFFFF) ? v : v + 32'h1;
	endfunction
	localparam logic [31:0] FILT_LAST = 32'(FILT_CYCLES - 1);
	localparam logic [31:0] DISC_LAST = 32'(DISC_CYCLES - 1);
	logic [`SIM_IN_W-1:0] pins;      // Raw pin levels, high = contact closed
	logic [`SIM_IN_W-1:0] sync1;     // First synchroniser stage
	logic [`SIM_IN_W-1:0] sync2;     // Second synchroniser stage
	logic [`SIM_IN_W-1:0] filt;      // Debounced levels
	logic [31:0]          filt_cnt [`SIM_IN_W];  // Stability counters
	assign pins = {i_teach_mode_sel, i_latch_release_in_first,
		i_door_input_b_first, i_door_input_a_first,
		i_stop_circuit_b_pos, i_stop_circuit_a_pos};
	// Two-stage synchroniser; the first stage feeds only the second
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			sync1 <= '0;
			sync2 <= '0;
		end else if (i_ce) begin
			sync1 <= pins;
			sync2 <= sync1;
		end
	end
	// Debounce: a level must hold FILT_CYCLES before it is believed.
	// Reset value is all open, so a missing plug reads as unsafe.
	for (genvar k = 0; k < `SIM_IN_W; k++) begin : g_filt
		always_ff @(posedge i_mclk or posedge i_reset) begin
			if (i_reset) begin
				filt[k]     <= 1'b0;
				filt_cnt[k] <= 32'h0;
			end else if (i_ce) begin
				if (sync2[k] == filt[k]) begin
					filt_cnt[k] <= 32'h0;
				end else if (filt_cnt[k] >= FILT_LAST) begin
					filt[k]     <= sync2[k];
					filt_cnt[k] <= 32'h0;
				end else begin
					filt_cnt[k] <= sat_inc(filt_cnt[k]);
				end
			end
		end
	end
	logic stop_ok;     // Both stop contacts closed
	logic door_ok;     // Both door contacts closed
	logic release_on;  // Latch release input closed
	logic teach_sel;   // Mode selector in teaching
	logic stop_agree;  // Stop channels agree
	logic door_agree;  // Door channels agree
	// Both channels must be closed; a single open contact counts as open
	assign stop_ok    = filt[`SIM_IN_STOP_A] & filt[`SIM_IN_STOP_B];
	assign door_ok    = filt[`SIM_IN_DOOR_A] & filt[`SIM_IN_DOOR_B];
	assign release_on = filt[`SIM_IN_RELEASE];
	assign teach_sel  = filt[`SIM_IN_TEACH];
	assign stop_agree = filt[`SIM_IN_STOP_A] == filt[`SIM_IN_STOP_B];
	assign door_agree = filt[`SIM_IN_DOOR_A] == filt[`SIM_IN_DOOR_B];
	logic [31:0] stop_disc_cnt;  // Cycles of stop disagreement
	logic [31:0] door_disc_cnt;  // Cycles of door disagreement
	logic        stop_timeout;   // Stop disagreement reached two seconds
	logic        door_timeout;   // Door disagreement reached two seconds
	logic        crit_stop;      // Sticky stop critical error
	logic        crit_door;      // Sticky door critical error
	logic        reset_cmd;      // One-cycle reset command from software
	assign stop_timeout = !stop_agree && stop_disc_cnt >= DISC_LAST;
	assign door_timeout = !door_agree && door_disc_cnt >= DISC_LAST;
	// Discrepancy timers restart as soon as the channels agree again
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			stop_disc_cnt <= 32'h0;
			door_disc_cnt <= 32'h0;
		end else if (i_ce) begin
			stop_disc_cnt <= stop_agree ? 32'h0 : sat_inc(stop_disc_cnt);
			door_disc_cnt <= door_agree ? 32'h0 : sat_inc(door_disc_cnt);
		end
	end
	// Critical errors: timeout sets, reset clears only once channels agree.
	// A timeout in the clearing cycle wins.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			crit_stop <= 1'b0;
			crit_door <= 1'b0;
		end else if (i_ce) begin
			if (stop_timeout) begin
				crit_stop <= 1'b1;
			end else if (reset_cmd && stop_agree) begin
				crit_stop <= 1'b0;
			end
			if (door_timeout) begin
				crit_door <= 1'b1;
			end else if (reset_cmd && door_agree) begin
				crit_door <= 1'b0;
			end
		end
	end
	logic door_latched;   // Door has been opened since last release
	logic teach_latched;  // Teaching has been selected since last release
	logic door_set;       // Door latch capture this cycle
	logic teach_set;      // Teach latch capture this cycle
	// Capture only while release is open; closed release blocks capture
	assign door_set  = !release_on && !door_ok && !door_latched;
	assign teach_set = !release_on && teach_sel && !teach_latched;
	// Latched records, cleared by a closed release input
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			door_latched  <= 1'b0;
			teach_latched <= 1'b0;
		end else if (i_ce) begin
			if (release_on) begin
				door_latched  <= 1'b0;
				teach_latched <= 1'b0;
			end else begin
				if (!door_ok) begin
					door_latched <= 1'b1;
				end
				if (teach_sel) begin
					teach_latched <= 1'b1;
				end
			end
		end
	end
	sim_pkg::sim_state_t state;       // Emergency stop sequencer
	sim_pkg::sim_state_t next_state;  // Its next value
	logic                crit_any;    // Any critical error pending
	assign crit_any = crit_stop | crit_door | stop_timeout | door_timeout;
	// Stop is left only through ARMED, which needs restored contacts,
	// so a reset issued while the button is still pressed does nothing
	always_comb begin
		next_state = state;
		unique case (state)
			sim_pkg::SIM_RUN: begin
				if (!stop_ok || crit_any) begin
					next_state = sim_pkg::SIM_STOP;
				end
			end
			sim_pkg::SIM_STOP: begin
				if (stop_ok && stop_agree && door_agree &&
						!stop_timeout && !door_timeout) begin
					next_state = sim_pkg::SIM_ARMED;
				end
			end
			sim_pkg::SIM_ARMED: begin
				if (!stop_ok || stop_timeout || door_timeout) begin
					next_state = sim_pkg::SIM_STOP;
				end else if (reset_cmd && stop_agree && door_agree) begin
					next_state = sim_pkg::SIM_RUN;
				end
			end
		endcase
	end
	// Power-up enters stop: nothing is trusted until a reset command
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			state <= sim_pkg::SIM_STOP;
		end else if (i_ce) begin
			state <= next_state;
		end
	end
	logic door_open_now;  // Door open, live or held
	// With release closed this reduces to the live input
	assign door_open_now = !door_ok || door_latched;
	// Registered safety outputs
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_estop          <= 1'b1;
			o_power_prohibit <= 1'b1;
			o_prog_hold      <= 1'b1;
			o_critical_error <= 1'b0;
			o_teach_latched  <= 1'b0;
		end else if (i_ce) begin
			o_estop <= next_state != sim_pkg::SIM_RUN;
			// Live door keeps power off even after a teach release
			o_power_prohibit <= next_state != sim_pkg::SIM_RUN ||
				door_open_now;
			o_prog_hold      <= door_open_now;
			o_critical_error <= crit_any;
			o_teach_latched  <= teach_latched | teach_set;
		end
	end

	logic                  bus_req;   // Request present
	logic                  bus_ack;   // Request completes this edge
	logic                  wr_ctrl;   // Write strobe to control
	logic [`SIM_IRQ_W-1:0] irq_stat;  // Sticky event bits
	logic [`SIM_IRQ_W-1:0] irq_mask;  // Interrupt enables
	logic [`SIM_IRQ_W-1:0] irq_ev;    // Events this cycle
	logic [`SIM_IRQ_W-1:0] irq_clr;   // Write-one-to-clear bits
	logic [31:0]           status;    // Live status word
	logic [31:0]           rd_mux;    // Read data selection

	// Every access gets exactly one wait cycle, then completes
	assign bus_req = i_avs_read | i_avs_write;
	assign bus_ack = bus_req & !o_avs_waitrequest;
	assign wr_ctrl = bus_ack && i_avs_write && i_avs_byteenable[0] &&
		i_avs_address == `SIM_REG_CTRL;

	// Waitrequest drops one cycle after the request and rises again after
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_avs_waitrequest <= 1'b1;
		end else if (i_ce) begin
			o_avs_waitrequest <= !(bus_req && o_avs_waitrequest);
		end
	end

	// Reset command pulse; all fields live in byte lane 0
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			reset_cmd <= 1'b0;
		end else if (i_ce) begin
			reset_cmd <= wr_ctrl && i_avs_writedata[`SIM_CTRL_RESET_CMD];
		end
	end

	always_comb begin
		irq_ev = '0;
		irq_ev[`SIM_IRQ_ESTOP] = state == sim_pkg::SIM_RUN &&
			next_state == sim_pkg::SIM_STOP;
		irq_ev[`SIM_IRQ_CRIT]  = (stop_timeout && !crit_stop) ||
			(door_timeout && !crit_door);
		irq_ev[`SIM_IRQ_DOOR]  = door_set;
		irq_ev[`SIM_IRQ_TEACH] = teach_set;
	end

	assign irq_clr = (bus_ack && i_avs_write && i_avs_byteenable[0] &&
		i_avs_address == `SIM_REG_IRQ_STAT) ?
		i_avs_writedata[`SIM_IRQ_W-1:0] : '0;

	// Sticky status: an event in the clearing cycle survives
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			irq_stat <= '0;
		end else if (i_ce) begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
		end
	end

	// Mask register, written as a whole low byte
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			irq_mask <= `SIM_IRQ_MASK_RST;
		end else if (i_ce && bus_ack && i_avs_write && i_avs_byteenable[0] &&
				i_avs_address == `SIM_REG_IRQ_MASK) begin
			irq_mask <= i_avs_writedata[`SIM_IRQ_W-1:0];
		end
	end

	// Level interrupt, registered in step with the status it reflects
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_irq <= 1'b0;
		end else if (i_ce) begin
			o_irq <= |(((irq_stat & ~irq_clr) | irq_ev) & irq_mask);
		end
	end

	always_comb begin
		status = '0;
		status[`SIM_ST_ESTOP]       = state != sim_pkg::SIM_RUN;
		status[`SIM_ST_PROHIBIT]    = state != sim_pkg::SIM_RUN || door_open_now;
		status[`SIM_ST_DOOR_OPEN]   = door_open_now;
		status[`SIM_ST_DOOR_LATCH]  = door_latched;
		status[`SIM_ST_TEACH_LATCH] = teach_latched;
		status[`SIM_ST_CRIT_DOOR]   = crit_door;
		status[`SIM_ST_CRIT_STOP]   = crit_stop;
		status[`SIM_ST_RELEASE]     = release_on;
		status[`SIM_ST_STOP_OK]     = stop_ok;
		status[`SIM_ST_DOOR_OK]     = door_ok;
		status[`SIM_ST_TEACH_SEL]   = teach_sel;
	end

	// Read decode; control and unmapped offsets read as zero
	always_comb begin
		rd_mux = 32'h0;
		unique case (i_avs_address)
			`SIM_REG_STATUS:   rd_mux = status;
			`SIM_REG_IRQ_STAT: rd_mux = {28'h0, irq_stat};
			`SIM_REG_IRQ_MASK: rd_mux = {28'h0, irq_mask};
			default:           rd_mux = 32'h0;
		endcase
	end

	// Read data lands with the waitrequest drop
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_avs_readdata <= 32'h0;
		end else if (i_ce) begin
			o_avs_readdata <= (i_avs_read && o_avs_waitrequest) ? rd_mux : 32'h0;
		end
	end

endmodule

// File: verif/sim_switches.sv
// Switch contacts at the connector; the bench commands each one
module sim_switches (
	input  wire logic i_plugged,      // Low: connector left open
	input  wire logic i_stop_closed,  // Stop button released
	input  wire logic i_stop_b_fault, // Second stop contact stuck open
	input  wire logic i_door_closed,  // Guard door shut
	input  wire logic i_door_b_fault, // Second door contact stuck open
	input  wire logic i_rel_closed,   // Latch release switch
	input  wire logic i_teach,        // Key switch on teaching
	output logic      o_stop_a,
	output logic      o_stop_b,
	output logic      o_door_a,
	output logic      o_door_b,
	output logic      o_rel,
	output logic      o_teach
);
	// An open connector reads as open contacts, the pull-down level
	assign o_stop_a = i_plugged & i_stop_closed;
	assign o_stop_b = i_plugged & i_stop_closed & ~i_stop_b_fault;
	assign o_door_a = i_plugged & i_door_closed;
	assign o_door_b = i_plugged & i_door_closed & ~i_door_b_fault;
	assign o_rel = i_plugged & i_rel_closed;
	assign o_teach = i_plugged & i_teach;
endmodule

// File: verif/sim_asserts.sv
module sim_asserts #(
	parameter int unsigned DISC_CYCLES = 50
) (
	input wire logic        i_mclk,
	input wire logic        i_reset,
	input wire logic        i_avs_read,
	input wire logic        i_avs_write,
	input wire logic        i_stop_circuit_a_pos,
	input wire logic        i_stop_circuit_b_pos,
	input wire logic        i_door_input_a_first,
	input wire logic        i_door_input_b_first,
	input wire logic [31:0] o_avs_readdata,
	input wire logic        o_avs_waitrequest,
	input wire logic        o_estop,
	input wire logic        o_power_prohibit,
	input wire logic        o_prog_hold,
	input wire logic        o_critical_error
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	int unsigned door_run; // Pin disagreement length, door pair
	int unsigned stop_run; // Pin disagreement length, stop pair
	int unsigned up_cnt;   // Cycles since reset, saturating
	// Runs restart on agreement, as the design's timers must
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			door_run <= 0;
			stop_run <= 0;
		end else begin
			door_run <= (i_door_input_a_first != i_door_input_b_first) ? door_run + 1 : 0;
			stop_run <= (i_stop_circuit_a_pos != i_stop_circuit_b_pos) ? stop_run + 1 : 0;
		end
	end
	// Saturates so the compare stays cheap on long runs
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			up_cnt <= 0;
		end else if (up_cnt < DISC_CYCLES) begin
			up_cnt <= up_cnt + 1;
		end
	end
	// Contact held open long enough to pass sync and filter
	sequence door_open_s;
		!i_door_input_a_first [*8];
	endsequence
	sequence stop_open_s;
		!i_stop_circuit_a_pos [*8];
	endsequence
	wait_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
		|=> !o_avs_waitrequest) else $error("bus answer late");
	wait_single_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low too long");
	readdata_idle_a: assert property (o_avs_waitrequest |-> o_avs_readdata == 32'h0)
		else $error("readdata outside answer");
	hold_prohibit_a: assert property (o_prog_hold |-> o_power_prohibit)
		else $error("hold without prohibit");
	estop_prohibit_a: assert property (o_estop |-> o_power_prohibit)
		else $error("stop without prohibit");
	crit_stop_a: assert property ($rose(o_critical_error) |-> ##[0:1] o_estop)
		else $error("critical error without stop");
	door_hold_a: assert property (door_open_s |=> ##1 o_prog_hold)
		else $error("open door not held");
	stop_trip_a: assert property (stop_open_s |=> ##1 o_estop)
		else $error("open stop contact ignored");
	crit_early_a: assert property (up_cnt < DISC_CYCLES |-> !o_critical_error)
		else $error("critical error too soon");
	crit_door_a: assert property (door_run == DISC_CYCLES + 12 |-> o_critical_error)
		else $error("door discrepancy missed");
	crit_pair_a: assert property (stop_run == DISC_CYCLES + 12 |-> o_critical_error)
		else $error("stop discrepancy missed");
endmodule

bind sim_monitor sim_asserts #(.DISC_CYCLES(DISC_CYCLES)) u_asserts (
	.i_mclk(i_mclk), .i_reset(i_reset), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.i_stop_circuit_a_pos(i_stop_circuit_a_pos), .i_stop_circuit_b_pos(i_stop_circuit_b_pos),
	.i_door_input_a_first(i_door_input_a_first), .i_door_input_b_first(i_door_input_b_first),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_estop(o_estop),
	.o_power_prohibit(o_power_prohibit), .o_prog_hold(o_prog_hold),
	.o_critical_error(o_critical_error));

// File: verif/safety_interlock_monitor_tb_top.sv
`include "sim_map.svh"
module safety_interlock_monitor_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned FILT = 4;  // Short filter keeps the run brief
	localparam int unsigned DISC = 50; // Short discrepancy time
	logic        i_mclk = 1'h0;
	logic        i_reset = 1'h1;
	logic        i_ce = 1'h1;          // Low only inside the freeze scenario
	logic [3:0]  i_avs_address = 4'h0;
	logic        i_avs_read = 1'h0;
	logic        i_avs_write = 1'h0;
	logic [31:0] i_avs_writedata = 32'h0;
	logic [3:0]  i_avs_byteenable = 4'hF;
	logic [31:0] o_avs_readdata;
	logic        o_avs_waitrequest, o_estop, o_power_prohibit, o_prog_hold;
	logic        o_critical_error, o_teach_latched, o_irq;
	logic        p_stop_a, p_stop_b, p_door_a, p_door_b, p_rel, p_teach; // Pins
	logic        sw_plug = 1'h0, sw_stop = 1'h1, sw_stop_bf = 1'h0, sw_door = 1'h1;
	logic        sw_door_bf = 1'h0, sw_rel = 1'h1, sw_teach = 1'h0;
	int          err_count = 0;
	int          cmp_count = 0;
	// Free-running 200 MHz clock
	always #2.5 i_mclk = ~i_mclk;
	sim_switches u_sw (.i_plugged(sw_plug), .i_stop_closed(sw_stop), .i_stop_b_fault(sw_stop_bf),
		.i_door_closed(sw_door), .i_door_b_fault(sw_door_bf), .i_rel_closed(sw_rel),
		.i_teach(sw_teach), .o_stop_a(p_stop_a), .o_stop_b(p_stop_b), .o_door_a(p_door_a),
		.o_door_b(p_door_b), .o_rel(p_rel), .o_teach(p_teach));
	sim_monitor #(.FILT_CYCLES(FILT), .DISC_CYCLES(DISC)) uut (.i_mclk(i_mclk),
		.i_reset(i_reset), .i_ce(i_ce), .i_stop_circuit_a_pos(p_stop_a),
		.i_stop_circuit_b_pos(p_stop_b), .i_door_input_a_first(p_door_a),
		.i_door_input_b_first(p_door_b), .i_latch_release_in_first(p_rel),
		.i_teach_mode_sel(p_teach), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
		.i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest), .o_estop(o_estop),
		.o_power_prohibit(o_power_prohibit), .o_prog_hold(o_prog_hold),
		.o_critical_error(o_critical_error), .o_teach_latched(o_teach_latched), .o_irq(o_irq));
	task automatic close_out();
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	// Long enough for sync, filter and output register
	task automatic settle();
		cyc(12);
	endtask
	task automatic chk(input logic got, input logic exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask
	// One Avalon transfer; request held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
			input logic [3:0] be, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge i_mclk);
		i_avs_write <= wr;
		i_avs_read <= ~wr;
		i_avs_address <= adr;
		i_avs_writedata <= wd;
		i_avs_byteenable <= be;
		do begin
			@(posedge i_mclk);
			n++;
		end while (o_avs_waitrequest !== 1'h0 && n < 50);
		rd = o_avs_readdata;
		if (o_avs_waitrequest !== 1'h0) begin
			err_count++;
			$display("[ERR] %0t bus hang", $time);
		end
		i_avs_write <= 1'h0;
		i_avs_read <= 1'h0;
		@(posedge i_mclk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'h1, a, d, 4'hF, r);
	endtask
	// Read and compare the masked bits
	task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] r;
		bus(1'h0, a, 32'h0, 4'hF, r);
		cmp_count++;
		if ((r & m) !== e) begin
			err_count++;
			$display("[ERR] %0t read %h got %h", $time, a, r);
		end
	endtask
	task automatic t_boot();
		settle();
		chk(o_power_prohibit, 1'h1, "open pins");
		rdc(`SIM_REG_STATUS, 32'h300, 32'h0);
		wr(`SIM_REG_CTRL, 32'h1);
		settle();
		chk(o_estop, 1'h1, "reset while open");
		sw_plug <= 1'h1;
		settle();
		chk(o_estop, 1'h1, "power up stop");
		wr(`SIM_REG_CTRL, 32'h1);
		cyc(3);
		chk(o_estop, 1'h0, "run");
		chk(o_power_prohibit, 1'h0, "power ok");
		rdc(4'h1, 32'hFFFFFFFF, 32'h0);
		rdc(`SIM_REG_CTRL, 32'hFFFFFFFF, 32'h0);
	endtask
	// Stop entry raises a sticky event; mask, clear and lane enable
	task automatic t_estop();
		logic [31:0] r;
		wr(`SIM_REG_IRQ_STAT, 32'hF);
		sw_stop <= 1'h0;
		settle();
		chk(o_estop, 1'h1, "stop open");
		chk(o_irq, 1'h0, "masked irq");
		rdc(`SIM_REG_IRQ_STAT, 32'h1, 32'h1);
		wr(`SIM_REG_IRQ_MASK, 32'h1);
		cyc(2);
		chk(o_irq, 1'h1, "irq raised");
		sw_stop <= 1'h1;
		settle();
		chk(o_estop, 1'h1, "needs reset");
		wr(`SIM_REG_IRQ_STAT, 32'h1);
		cyc(2);
		chk(o_irq, 1'h0, "irq cleared");
		bus(1'h1, `SIM_REG_IRQ_MASK, 32'h0, 4'h0, r);
		rdc(`SIM_REG_IRQ_MASK, 32'hF, 32'h1);
		wr(`SIM_REG_IRQ_MASK, 32'h0);
		wr(`SIM_REG_CTRL, 32'h1);
		cyc(3);
		chk(o_estop, 1'h0, "recovered");
	endtask
	task automatic t_door();
		sw_rel <= 1'h0;
		sw_door <= 1'h0;
		settle();
		chk(o_prog_hold, 1'h1, "door open hold");
		chk(o_power_prohibit, 1'h1, "door open power");
		rdc(`SIM_REG_STATUS, 32'h8, 32'h8);
		sw_door <= 1'h1;
		settle();
		chk(o_prog_hold, 1'h1, "door held");
		sw_rel <= 1'h1;
		settle();
		chk(o_prog_hold, 1'h0, "door released");
		sw_door <= 1'h0;
		settle();
		chk(o_prog_hold, 1'h1, "live door open");
		sw_door <= 1'h1;
		settle();
		chk(o_prog_hold, 1'h0, "live door closed");
	endtask
	task automatic t_teach();
		sw_rel <= 1'h0;
		sw_teach <= 1'h1;
		settle();
		chk(o_teach_latched, 1'h1, "teach latched");
		sw_teach <= 1'h0;
		settle();
		chk(o_teach_latched, 1'h1, "teach held");
		sw_rel <= 1'h1;
		settle();
		chk(o_teach_latched, 1'h0, "teach released");
		sw_rel <= 1'h0;
		sw_door <= 1'h0;
		sw_teach <= 1'h1;
		settle();
		sw_teach <= 1'h0;
		sw_rel <= 1'h1;
		settle();
		chk(o_teach_latched, 1'h0, "teach off door open");
		chk(o_power_prohibit, 1'h1, "live door prohibits");
		sw_door <= 1'h1;
		settle();
		chk(o_power_prohibit, 1'h0, "door closed again");
	endtask
	task automatic fault(input logic p, input logic v);
		if (p) sw_stop_bf <= v;
		else sw_door_bf <= v;
	endtask
	// Short runs with a filtered gap must not add up; a long run trips
	task automatic t_crit(input logic p);
		for (int k = 0; k < 2; k++) begin
			fault(p, 1'h1);
			cyc(DISC - 20);
			fault(p, 1'h0);
			settle();
		end
		chk(o_critical_error, 1'h0, "short disagreement");
		fault(p, 1'h1);
		cyc(DISC + 20);
		chk(o_critical_error, 1'h1, "long disagreement");
		chk(o_estop, 1'h1, "crit stops");
		rdc(`SIM_REG_STATUS, 32'h60, p ? 32'h40 : 32'h20);
		fault(p, 1'h0);
		settle();
		chk(o_critical_error, 1'h1, "crit holds");
		wr(`SIM_REG_CTRL, 32'h1);
		wr(`SIM_REG_CTRL, 32'h1);
		cyc(3);
		chk(o_critical_error, 1'h0, "crit cleared");
		chk(o_estop, 1'h0, "run after crit");
	endtask
	// Low enable must hold every register, filters and latches included
	task automatic t_freeze();
		i_ce <= 1'h0;
		sw_rel <= 1'h0;
		sw_teach <= 1'h1;
		cyc(20);
		chk(o_teach_latched, 1'h0, "frozen latch");
		i_ce <= 1'h1;
		settle();
		chk(o_teach_latched, 1'h1, "thawed latch");
		sw_teach <= 1'h0;
		sw_rel <= 1'h1;
		settle();
		chk(o_teach_latched, 1'h0, "thawed release");
	endtask
	// Main sequence
	initial begin
		cyc(20);
		chk(o_estop, 1'h1, "reset stop");
		chk(o_prog_hold, 1'h1, "reset hold");
		i_reset <= 1'h0;
		t_boot();
		t_estop();
		t_door();
		t_teach();
		t_freeze();
		t_crit(1'h0);
		t_crit(1'h1);
		close_out();
	end
	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		cyc(20000);
		err_count++;
		close_out();
	end
endmodule
